/* File: rtl/intc_pkg.sv */
// Constants, types and helpers shared by the interrupt accept and NMI logic.
package intc_pkg;
    localparam int NUM_SRC = 8;
    localparam int SRC_W = 3;
    localparam int LVL_W = 3;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 6;
    localparam int SP_W = 16;
    localparam int NUM_EV = 3;

    // Byte addresses of the register map; reading ADDR_VECT is the vector fetch.
    localparam logic [ADDR_W-1:0] ADDR_VECT = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_PEND = 6'h04;
    localparam logic [ADDR_W-1:0] ADDR_EN = 6'h08;
    localparam logic [ADDR_W-1:0] ADDR_PRIO = 6'h0c;
    localparam logic [ADDR_W-1:0] ADDR_USP = 6'h10;
    localparam logic [ADDR_W-1:0] ADDR_ISP = 6'h14;
    localparam logic [ADDR_W-1:0] ADDR_CLK = 6'h18;
    localparam logic [ADDR_W-1:0] ADDR_PORT8 = 6'h1c;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 6'h20;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 6'h24;

    localparam logic [SP_W-1:0] SP_RESET = 16'h0000;
    localparam logic [NUM_SRC-1:0] EN_RESET = 8'h00;
    localparam logic [NUM_SRC*LVL_W-1:0] PRIO_RESET = 24'h000000;
    localparam logic [NUM_EV-1:0] EV_RESET = 3'h0;

    // Field positions.
    localparam int CLK_STOP_BIT = 0;
    localparam int CLK_WAIT_BIT = 1;
    localparam int PORT8_NMI_BIT = 5;
    localparam int EV_NMI = 0;
    localparam int EV_ACCEPT = 1;
    localparam int EV_WAKE = 2;

    typedef struct packed {
        logic valid;
        logic [LVL_W-1:0] lvl;
        logic [SRC_W-1:0] num;
    } vect_s;

    localparam int VECT_W = 1 + LVL_W + SRC_W;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_WAIT = 2'b01,
        PWR_STOP = 2'b10,
        PWR_HALT = 2'b11
    } pwr_e;

    // One-hot mask of a source number, used for the accept and vector-read pending-flag clears.
    function automatic logic [NUM_SRC-1:0] src_onehot(input logic en, input logic [SRC_W-1:0] n);
        logic [NUM_SRC-1:0] m;
        m = '0;
        m[n] = en;
        return m;
    endfunction
endpackage

/* File: rtl/nmi_sync.sv */
// Two-stage synchroniser and falling-edge detector for the NMI pin.
`timescale 1ns/1ps
`default_nettype none
module nmi_sync (
    input wire logic i_mclk,   // CPU clock
    input wire logic i_reset,  // Synchronous reset, active high
    input wire logic i_nmi_n,  // Raw NMI pin, active low
    output logic o_level,      // Synchronised pin level
    output logic o_fall        // One-cycle pulse per falling edge
);
    logic meta_r, meta_nxt;
    logic sync_r, sync_nxt;
    logic prev_r, prev_nxt;

    // Only sync_r reads meta_r, so a metastable sample never reaches the edge logic.
    always_comb begin
        meta_nxt = i_nmi_n;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    // Reset to high so an idle pulled-up pin produces no edge after reset.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign o_level = sync_r;
    assign o_fall = prev_r & ~sync_r;
endmodule
`default_nettype wire

/* File: rtl/prio_pick.sv */
// Selects the highest-priority enabled pending source; lowest number wins a tie.
`timescale 1ns/1ps
`default_nettype none
module prio_pick (
    input wire logic [intc_pkg::NUM_SRC-1:0] i_pend,                // Pending flags
    input wire logic [intc_pkg::NUM_SRC-1:0] i_en,                  // Source enables
    input wire logic [intc_pkg::NUM_SRC*intc_pkg::LVL_W-1:0] i_prio, // Levels
    output intc_pkg::vect_s o_best                                  // Winner
);
    always_comb begin
        o_best = '0;
        for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (i_pend[i] && i_en[i] &&
                (!o_best.valid || i_prio[i*intc_pkg::LVL_W +: intc_pkg::LVL_W] >= o_best.lvl)) begin
                o_best.valid = 1'b1;
                o_best.lvl = i_prio[i*intc_pkg::LVL_W +: intc_pkg::LVL_W];
                o_best.num = intc_pkg::SRC_W'(i);
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/intc_accept_nmi.sv */
// Interrupt acceptance, stack pointer reset, power-mode control and NMI handling.
// Function
// - On acceptance, return number and level from the vector fetch and clear its flag.
// - A software read of the vector fetch clears the winning enabled pending flag.
// - Reset clears both user and interrupt stack pointers to zero.
// - All interrupts, NMI included, stay blocked until the first instruction completes.
// - Nothing in software can mask or disable the NMI request.
// - The NMI pin level is readable in a port data bit.
// - While NMI is low the all-clock-stop bit is forced to zero.
// - NMI going low in wait mode halts the CPU until a later interrupt.
// - Writing one to the all-clock-stop bit enters stop mode; prefetch may still run.
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module intc_accept_nmi (
    input wire logic i_mclk,                                   // CPU clock, 40 MHz
    input wire logic i_reset,                                  // Synchronous reset, active high
    input wire logic [intc_pkg::ADDR_W-1:0] i_address,         // Avalon byte address
    input wire logic i_read,                                   // Avalon read
    input wire logic i_write,                                  // Avalon write
    input wire logic [intc_pkg::DATA_W-1:0] i_writedata,       // Avalon write data
    output logic [intc_pkg::DATA_W-1:0] o_readdata,            // Avalon read data
    output logic o_waitrequest,                                // Avalon wait request
    input wire logic [intc_pkg::NUM_SRC-1:0] i_src_req,        // Maskable request pulses
    input wire logic i_nmi_n,                                  // NMI pin, active low
    input wire logic i_instr_done,                             // Pulse per retired instruction
    input wire logic i_cpu_iflag,                              // CPU interrupt enable flag
    input wire logic [intc_pkg::LVL_W-1:0] i_cpu_ipl,          // CPU priority level
    input wire logic i_int_ack,                                // CPU accepts maskable request
    input wire logic i_nmi_ack,                                // CPU accepts NMI
    output logic o_int_req,                                    // Maskable request to CPU
    output intc_pkg::vect_s o_int_vect,                        // Fetched number and level
    output logic o_nmi_req,                                    // NMI request to CPU
    output logic [intc_pkg::SP_W-1:0] o_usp,                   // User stack pointer
    output logic [intc_pkg::SP_W-1:0] o_isp,                   // Interrupt stack pointer
    output intc_pkg::pwr_e o_pwr_state,                        // Power mode
    output logic o_irq                                         // Status interrupt, active high
);
    logic nmi_level;
    logic nmi_fall;
    intc_pkg::vect_s best;

    nmi_sync u_nmi_sync (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_nmi_n(i_nmi_n),
        .o_level(nmi_level),
        .o_fall(nmi_fall)
    );

    // Bus slave state.
    logic wait_r, wait_nxt;
    logic [intc_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
    intc_pkg::vect_s rd_vect_r, rd_vect_nxt;
    logic req;
    logic done;
    logic wr_done;

    // Interrupt controller state.
    logic [intc_pkg::NUM_SRC-1:0] pend_r, pend_nxt;
    logic [intc_pkg::NUM_SRC-1:0] en_r, en_nxt;
    logic [intc_pkg::NUM_SRC*intc_pkg::LVL_W-1:0] prio_r, prio_nxt;
    logic [intc_pkg::SP_W-1:0] usp_r, usp_nxt;
    logic [intc_pkg::SP_W-1:0] isp_r, isp_nxt;
    logic armed_r, armed_nxt;
    logic nmi_pend_r, nmi_pend_nxt;
    logic int_req_r, int_req_nxt;
    logic nmi_req_r, nmi_req_nxt;
    intc_pkg::vect_s vect_r, vect_nxt;
    intc_pkg::pwr_e pwr_r, pwr_nxt;
    logic [intc_pkg::NUM_EV-1:0] stat_r, stat_nxt;
    logic [intc_pkg::NUM_EV-1:0] mask_r, mask_nxt;
    logic irq_r, irq_nxt;
    logic [intc_pkg::NUM_EV-1:0] ev;
    logic [intc_pkg::NUM_SRC-1:0] clr;
    logic new_int;

    prio_pick u_prio_pick (
        .i_pend(pend_r),
        .i_en(en_r),
        .i_prio(prio_r),
        .o_best(best)
    );

    assign req = i_read | i_write;
    assign done = req & ~wait_r;
    assign wr_done = i_write & ~wait_r;

    // One wait state per access: data is prepared, then presented with waitrequest low.
    always_comb begin
        wait_nxt = ~(req & wait_r);
        rdata_nxt = rdata_r;
        rd_vect_nxt = rd_vect_r;
        if (req && wait_r) begin
            rdata_nxt = '0;
            rd_vect_nxt = '0;
            unique case (i_address)
                intc_pkg::ADDR_VECT: begin
                    rdata_nxt[intc_pkg::VECT_W-1:0] = best;
                    rd_vect_nxt = best;
                end
                intc_pkg::ADDR_PEND: rdata_nxt[intc_pkg::NUM_SRC-1:0] = pend_r;
                intc_pkg::ADDR_EN: rdata_nxt[intc_pkg::NUM_SRC-1:0] = en_r;
                intc_pkg::ADDR_PRIO: rdata_nxt[intc_pkg::NUM_SRC*intc_pkg::LVL_W-1:0] = prio_r;
                intc_pkg::ADDR_USP: rdata_nxt[intc_pkg::SP_W-1:0] = usp_r;
                intc_pkg::ADDR_ISP: rdata_nxt[intc_pkg::SP_W-1:0] = isp_r;
                intc_pkg::ADDR_CLK: begin
                    rdata_nxt[intc_pkg::CLK_STOP_BIT] = (pwr_r == intc_pkg::PWR_STOP);
                    rdata_nxt[intc_pkg::CLK_WAIT_BIT] = (pwr_r == intc_pkg::PWR_WAIT) ||
                                                        (pwr_r == intc_pkg::PWR_HALT);
                end
                intc_pkg::ADDR_PORT8: rdata_nxt[intc_pkg::PORT8_NMI_BIT] = nmi_level;
                intc_pkg::ADDR_STAT: rdata_nxt[intc_pkg::NUM_EV-1:0] = stat_r;
                intc_pkg::ADDR_MASK: rdata_nxt[intc_pkg::NUM_EV-1:0] = mask_r;
                default: rdata_nxt = '0;
            endcase
            if (!i_read) begin
                rdata_nxt = '0;
                rd_vect_nxt = '0;
            end
        end
    end

    // Pending flags, vector latch and CPU requests.
    always_comb begin
        clr = intc_pkg::src_onehot(i_int_ack & best.valid, best.num);
        if (done && i_read && i_address == intc_pkg::ADDR_VECT) begin
            clr = clr | intc_pkg::src_onehot(rd_vect_r.valid, rd_vect_r.num);
        end
        if (wr_done && i_address == intc_pkg::ADDR_PEND) begin
            clr = clr | i_writedata[intc_pkg::NUM_SRC-1:0];
        end
        // A request arriving in the clearing cycle survives.
        pend_nxt = (pend_r & ~clr) | i_src_req;
        vect_nxt = vect_r;
        if (i_int_ack) begin
            vect_nxt = best;
        end
        armed_nxt = armed_r | i_instr_done;
        // No enable or mask term touches the NMI path.
        nmi_pend_nxt = (nmi_pend_r & ~i_nmi_ack) | nmi_fall;
        nmi_req_nxt = nmi_pend_nxt & armed_nxt;
        int_req_nxt = armed_nxt && i_cpu_iflag && best.valid &&
                      (best.lvl > i_cpu_ipl) && !i_int_ack && !clr[best.num];
    end

    // Enables, levels and stack pointers change only through bus writes.
    always_comb begin
        en_nxt = en_r;
        prio_nxt = prio_r;
        usp_nxt = usp_r;
        isp_nxt = isp_r;
        if (wr_done) begin
            unique case (i_address)
                intc_pkg::ADDR_EN: en_nxt = i_writedata[intc_pkg::NUM_SRC-1:0];
                intc_pkg::ADDR_PRIO: prio_nxt = i_writedata[intc_pkg::NUM_SRC*intc_pkg::LVL_W-1:0];
                // Software must load these before enabling interrupts.
                intc_pkg::ADDR_USP: usp_nxt = i_writedata[intc_pkg::SP_W-1:0];
                intc_pkg::ADDR_ISP: isp_nxt = i_writedata[intc_pkg::SP_W-1:0];
                default: ;
            endcase
        end
    end

    // Power modes: stop, wait and the NMI-induced halt.
    always_comb begin
        new_int = nmi_fall | (|(i_src_req & en_r));
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            intc_pkg::PWR_RUN: begin
                if (wr_done && i_address == intc_pkg::ADDR_CLK) begin
                    // The stop bit reads as zero while NMI is low, so the write is dropped.
                    if (i_writedata[intc_pkg::CLK_STOP_BIT] && nmi_level) begin
                        // Stop takes effect here; already prefetched code may still retire.
                        pwr_nxt = intc_pkg::PWR_STOP;
                    end else if (i_writedata[intc_pkg::CLK_WAIT_BIT]) begin
                        pwr_nxt = intc_pkg::PWR_WAIT;
                    end
                end
            end
            intc_pkg::PWR_STOP: begin
                if (!nmi_level) begin
                    pwr_nxt = intc_pkg::PWR_RUN;
                end else if (new_int) begin
                    pwr_nxt = intc_pkg::PWR_RUN;
                end
            end
            intc_pkg::PWR_WAIT: begin
                if (nmi_fall) begin
                    pwr_nxt = intc_pkg::PWR_HALT;
                end else if (new_int) begin
                    pwr_nxt = intc_pkg::PWR_RUN;
                end
            end
            intc_pkg::PWR_HALT: begin
                // The clock keeps running here, so the halt saves no power.
                if (new_int) begin
                    pwr_nxt = intc_pkg::PWR_RUN;
                end
            end
        endcase
    end

    // Status, mask and the combined interrupt line; a new event beats a clear.
    always_comb begin
        ev = '0;
        ev[intc_pkg::EV_NMI] = nmi_fall;
        ev[intc_pkg::EV_ACCEPT] = i_int_ack;
        ev[intc_pkg::EV_WAKE] = (pwr_r != intc_pkg::PWR_RUN) && (pwr_nxt == intc_pkg::PWR_RUN);
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        if (wr_done && i_address == intc_pkg::ADDR_STAT) begin
            stat_nxt = stat_r & ~i_writedata[intc_pkg::NUM_EV-1:0];
        end
        if (wr_done && i_address == intc_pkg::ADDR_MASK) begin
            mask_nxt = i_writedata[intc_pkg::NUM_EV-1:0];
        end
        stat_nxt = stat_nxt | ev;
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    // Bus slave registers; waitrequest idles high so a new request always waits once.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wait_r <= 1'b1;
            rdata_r <= '0;
            rd_vect_r <= '0;
        end else begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            rd_vect_r <= rd_vect_nxt;
        end
    end

    // Configuration registers.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            en_r <= intc_pkg::EN_RESET;
            prio_r <= intc_pkg::PRIO_RESET;
            usp_r <= intc_pkg::SP_RESET;
            isp_r <= intc_pkg::SP_RESET;
        end else begin
            en_r <= en_nxt;
            prio_r <= prio_nxt;
            usp_r <= usp_nxt;
            isp_r <= isp_nxt;
        end
    end

    // Request state.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            pend_r <= '0;
            armed_r <= 1'b0;
            nmi_pend_r <= 1'b0;
            int_req_r <= 1'b0;
            nmi_req_r <= 1'b0;
            vect_r <= '0;
        end else begin
            pend_r <= pend_nxt;
            armed_r <= armed_nxt;
            nmi_pend_r <= nmi_pend_nxt;
            int_req_r <= int_req_nxt;
            nmi_req_r <= nmi_req_nxt;
            vect_r <= vect_nxt;
        end
    end

    // Power mode.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            pwr_r <= intc_pkg::PWR_RUN;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // Status, mask and interrupt line.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            stat_r <= intc_pkg::EV_RESET;
            mask_r <= intc_pkg::EV_RESET;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign o_readdata = rdata_r;
    assign o_waitrequest = wait_r;
    assign o_int_req = int_req_r;
    assign o_int_vect = vect_r;
    assign o_nmi_req = nmi_req_r;
    assign o_usp = usp_r;
    assign o_isp = isp_r;
    assign o_pwr_state = pwr_r;
    assign o_irq = irq_r;
endmodule
`default_nettype wire

/* File: tb/intc_accept_nmi_assertions.sv */
// Concurrent checks of the interrupt accept and NMI block at its ports.
`timescale 1ns/1ps
`default_nettype none
module intc_accept_nmi_assertions (
    input wire logic i_mclk, // clock
    input wire logic i_reset, // reset
    input wire logic [intc_pkg::ADDR_W-1:0] i_address, // address
    input wire logic i_read, // read
    input wire logic i_write, // write
    input wire logic [intc_pkg::DATA_W-1:0] o_readdata, // read data
    input wire logic o_waitrequest, // wait request
    input wire logic i_nmi_n, // NMI pin
    input wire logic i_instr_done, // retire pulse
    input wire logic i_int_ack, // accept
    input wire logic i_nmi_ack, // NMI accept
    input wire logic o_int_req, // request
    input wire intc_pkg::vect_s o_int_vect, // vector
    input wire logic o_nmi_req, // NMI request
    input wire logic [intc_pkg::SP_W-1:0] o_usp, // user stack
    input wire logic [intc_pkg::SP_W-1:0] o_isp, // interrupt stack
    input wire intc_pkg::pwr_e o_pwr_state // power mode
);
    logic armed_r;
    logic armed_nxt;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    always_comb armed_nxt = armed_r | i_instr_done;
    always_ff @(posedge i_mclk) armed_r <= i_reset ? 1'h0 : armed_nxt;

    // The pin is raw, so a fall counts only once it has stayed low long enough to pass sync.
    sequence s_nmi_fall;
        $fell(i_nmi_n) ##1 (!i_nmi_n) [*3];
    endsequence
    sequence s_low_held;
        (!i_nmi_n) [*6];
    endsequence

    property p_sp_reset;
        disable iff (1'h0) i_reset |=> o_usp == '0 && o_isp == '0;
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("stack pointers not cleared");
    property p_reset_quiet;
        disable iff (1'h0) i_reset |=> !o_int_req && !o_nmi_req
            && o_pwr_state == intc_pkg::PWR_RUN;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("request after reset");
    property p_no_int_before_arm;
        !armed_r |-> !o_int_req && !o_nmi_req;
    endproperty
    a_no_int_before_arm: assert property (p_no_int_before_arm) else $error("early request");
    property p_vect_on_ack;
        i_int_ack && o_int_req |=> o_int_vect.valid && !o_int_req;
    endproperty
    a_vect_on_ack: assert property (p_vect_on_ack) else $error("accept not taken");
    property p_nmi_req_rise;
        armed_r ##0 s_nmi_fall |-> ##[0:3] o_nmi_req;
    endproperty
    a_nmi_req_rise: assert property (p_nmi_req_rise) else $error("NMI request missing");
    property p_one_req_per_pulse;
        s_low_held ##0 i_nmi_ack |=> (!o_nmi_req) [*3];
    endproperty
    a_one_req_per_pulse: assert property (p_one_req_per_pulse) else $error("NMI repeated");
    property p_stop_blocked;
        s_low_held |-> o_pwr_state != intc_pkg::PWR_STOP;
    endproperty
    a_stop_blocked: assert property (p_stop_blocked) else $error("stop while NMI low");
    property p_wait_halt;
        (o_pwr_state == intc_pkg::PWR_WAIT) ##0 s_nmi_fall |-> ##[0:3]
            o_pwr_state == intc_pkg::PWR_HALT;
    endproperty
    a_wait_halt: assert property (p_wait_halt) else $error("wait did not halt");
    property p_port8_level;
        $stable(i_nmi_n) [*5] ##0 (i_read && !o_waitrequest
            && i_address == intc_pkg::ADDR_PORT8) |-> o_readdata[5] == i_nmi_n;
    endproperty
    a_port8_level: assert property (p_port8_level) else $error("pin level wrong");
    property p_one_wait;
        (i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus wait state wrong");
endmodule

bind intc_accept_nmi intc_accept_nmi_assertions u_chk (
    .i_mclk, .i_reset, .i_address, .i_read, .i_write, .o_readdata, .o_waitrequest,
    .i_nmi_n, .i_instr_done, .i_int_ack, .i_nmi_ack, .o_int_req, .o_int_vect,
    .o_nmi_req, .o_usp, .o_isp, .o_pwr_state
);
`default_nettype wire

/* File: tb/nmi_source.sv */
// Model of the external circuit that drives the NMI pin.
`timescale 1ns/1ps
`default_nettype none
module nmi_source #(
    parameter int HOLD_CYC = 14 // Two clocks plus 300 ns at 25 ns a clock.
) (
    input wire logic i_mclk, // CPU clock
    output logic o_nmi_n // NMI pin, idle high through the pull-up
);
    initial o_nmi_n = 1'h1;

    // Each level is held its minimum width before the caller may change it.
    task automatic drive(input logic v);
        @(posedge i_mclk);
        o_nmi_n <= v;
        repeat (HOLD_CYC) @(posedge i_mclk);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the interrupt accept and NMI block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
    logic i_mclk = 1'h0;
    logic i_reset = 1'h1;
    logic i_read = 1'h0;
    logic i_write = 1'h0;
    logic i_instr_done = 1'h0;
    logic i_cpu_iflag = 1'h1;
    logic i_int_ack = 1'h0;
    logic i_nmi_ack = 1'h0;
    logic [5:0] i_address = 6'h00;
    logic [31:0] i_writedata = 32'h0;
    logic [7:0] i_src_req = 8'h00;
    logic [2:0] i_cpu_ipl = 3'h0;
    wire logic i_nmi_n;
    logic [31:0] o_readdata, rd;
    logic o_waitrequest, o_int_req, o_nmi_req, o_irq;
    intc_pkg::vect_s o_int_vect;
    logic [15:0] o_usp, o_isp;
    intc_pkg::pwr_e o_pwr_state;
    int err_total = 0;
    int checked = 0;

    always #12.5 i_mclk = ~i_mclk;

    nmi_source u_nmi (.i_mclk(i_mclk), .o_nmi_n(i_nmi_n));
    intc_accept_nmi DUT (
        .i_mclk, .i_reset, .i_address, .i_read, .i_write, .i_writedata, .o_readdata,
        .o_waitrequest, .i_src_req, .i_nmi_n, .i_instr_done, .i_cpu_iflag, .i_cpu_ipl,
        .i_int_ack, .i_nmi_ack, .o_int_req, .o_int_vect, .o_nmi_req, .o_usp, .o_isp,
        .o_pwr_state, .o_irq
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    // Waitrequest is read just after each rising edge, before the design's flops
    // update, so the value seen is the one sampled at that edge.
    task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_address <= a;
        i_writedata <= d;
        i_write <= we;
        i_read <= ~we;
        do @(posedge i_mclk); while (o_waitrequest !== 1'h0);
        rd = o_readdata;
        i_read <= 1'h0;
        i_write <= 1'h0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask
    task automatic rchk(input string n, input logic [5:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        `CHK(n, e, rd)
    endtask
    // Bits are source requests, retire, accept and NMI accept, high for one cycle.
    task automatic pulse(input logic [10:0] v);
        @(posedge i_mclk);
        i_src_req <= v[10:3];
        i_instr_done <= v[2];
        i_int_ack <= v[1];
        i_nmi_ack <= v[0];
        @(posedge i_mclk);
        i_src_req <= 8'h00;
        i_instr_done <= 1'h0;
        i_int_ack <= 1'h0;
        i_nmi_ack <= 1'h0;
    endtask
    task automatic test_done();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        cyc(4000);
        err_total++;
        test_done();
    end

    initial begin
        cyc(16);
        i_reset <= 1'h0;
        `CHK("rst", {32'h0, intc_pkg::PWR_RUN, 4'h1}, {o_usp, o_isp, o_pwr_state,
            o_int_req, o_nmi_req, o_irq, o_waitrequest})
        rchk("usp0", intc_pkg::ADDR_USP, 32'h0);
        rchk("isp0", intc_pkg::ADDR_ISP, 32'h0);
        wr(intc_pkg::ADDR_USP, 32'h1234);
        wr(intc_pkg::ADDR_ISP, 32'h2468);
        wr(intc_pkg::ADDR_EN, 32'h4a);
        wr(intc_pkg::ADDR_PRIO, 32'h140a10);
        `CHK("sp", 32'h24681234, {o_isp, o_usp})
        pulse(11'h240);
        u_nmi.drive(1'h0);
        u_nmi.drive(1'h1);
        `CHK("blocked", 2'h0, {o_int_req, o_nmi_req})
        pulse(11'h004);
        cyc(4);
        `CHK("armed", 2'h3, {o_int_req, o_nmi_req})
        i_cpu_ipl <= 3'h5;
        cyc(2);
        `CHK("ipl_eq", 1'h0, o_int_req)
        i_cpu_ipl <= 3'h4;
        cyc(2);
        `CHK("ipl_lt", 1'h1, o_int_req)
        rchk("stat", intc_pkg::ADDR_STAT, 32'h1);
        wr(intc_pkg::ADDR_MASK, 32'h1);
        cyc(2);
        `CHK("irq", 1'h1, o_irq)
        wr(intc_pkg::ADDR_STAT, 32'h1);
        cyc(2);
        `CHK("irq_clr", 1'h0, o_irq)
        pulse(11'h001);
        cyc(2);
        `CHK("nmi_ack", 1'h0, o_nmi_req)
        pulse(11'h002);
        cyc(1);
        `CHK("vect", 7'h6b, o_int_vect)
        rchk("pend", intc_pkg::ADDR_PEND, 32'h40);
        rchk("vect_rd", intc_pkg::ADDR_VECT, 32'h6e);
        rchk("pend_rd", intc_pkg::ADDR_PEND, 32'h0);
        pulse(11'h018);
        cyc(2);
        rchk("vect_en", intc_pkg::ADDR_VECT, 32'h51);
        rchk("pend_en", intc_pkg::ADDR_PEND, 32'h1);
        rchk("hole", 6'h3c, 32'h0);
        rchk("pin_hi", intc_pkg::ADDR_PORT8, 32'h20);
        u_nmi.drive(1'h0);
        rchk("pin_lo", intc_pkg::ADDR_PORT8, 32'h0);
        wr(intc_pkg::ADDR_CLK, 32'h1);
        rchk("clk_lo", intc_pkg::ADDR_CLK, 32'h0);
        pulse(11'h001);
        cyc(4);
        `CHK("one_req", 1'h0, o_nmi_req)
        u_nmi.drive(1'h1);
        wr(intc_pkg::ADDR_CLK, 32'h1);
        rchk("clk_stop", intc_pkg::ADDR_CLK, 32'h1);
        `CHK("stop", intc_pkg::PWR_STOP, o_pwr_state)
        u_nmi.drive(1'h0);
        `CHK("wake", intc_pkg::PWR_RUN, o_pwr_state)
        pulse(11'h001);
        u_nmi.drive(1'h1);
        wr(intc_pkg::ADDR_CLK, 32'h2);
        cyc(1);
        `CHK("wait", intc_pkg::PWR_WAIT, o_pwr_state)
        i_cpu_iflag <= 1'h0;
        u_nmi.drive(1'h0);
        `CHK("halt", intc_pkg::PWR_HALT, o_pwr_state)
        `CHK("nmi_iflag", 1'h1, o_nmi_req)
        pulse(11'h001);
        i_cpu_iflag <= 1'h1;
        u_nmi.drive(1'h1);
        pulse(11'h010);
        cyc(3);
        `CHK("resume", intc_pkg::PWR_RUN, o_pwr_state)
        test_done();
    end
endmodule
`default_nettype wire
